// ### design/amp_pkg.sv
/*
  shared constants, types and reset values for the alarm monitor panel.
  assumes a single 25 MHz clock domain and a byte-wide register port.
*/
package amp_pkg;

  localparam int AMP_CHANNELS = 14;
  localparam int AMP_ANALOG = 12;
  localparam int AMP_MEM_BYTES = 80;

  localparam logic [6:0] AMP_HI_BASE = 7'h00;
  localparam logic [6:0] AMP_LO_BASE = 7'h10;
  localparam logic [6:0] AMP_SEV_BASE = 7'h20;
  localparam logic [6:0] AMP_SEV_LAST = 7'h2d;
  localparam logic [6:0] AMP_CFG_ADDR = 7'h30;
  localparam logic [6:0] AMP_SER_ADDR = 7'h31;
  localparam logic [6:0] AMP_ID_BASE = 7'h38;
  localparam logic [6:0] AMP_ID_LAST = 7'h3b;
  localparam logic [6:0] AMP_PHONE_BASE = 7'h40;
  localparam logic [6:0] AMP_PHONE_LAST = 7'h4f;
  localparam logic [6:0] AMP_STAT_LO_ADDR = 7'h50;
  localparam logic [6:0] AMP_STAT_HI_ADDR = 7'h51;
  localparam logic [6:0] AMP_COUNT_ADDR = 7'h52;
  localparam logic [6:0] AMP_POWER_ADDR = 7'h53;

  localparam int AMP_CFG_BUZZ = 0;
  localparam int AMP_CFG_ROLL = 1;
  localparam int AMP_CFG_MINOR = 2;
  localparam int AMP_CFG_MAJOR = 3;
  localparam int AMP_CFG_CRIT = 4;
  localparam int AMP_CFG_PG_POL = 5;
  localparam int AMP_CFG_PF_POL = 6;

  localparam int AMP_SER_MODE_LSB = 0;
  localparam int AMP_SER_BAUD_LSB = 2;

  localparam logic [1:0] AMP_PORT_P2P = 2'h0;
  localparam logic [1:0] AMP_PORT_MULTIDROP = 2'h1;
  localparam logic [1:0] AMP_DIALOUT_PORT_MODE = 2'h2;

  localparam logic [7:0] AMP_HEX_MAX = 8'h0f;
  localparam logic [7:0] AMP_DEC_MAX = 8'h09;
  localparam logic [7:0] AMP_SEV_MAX = 8'h03;
  localparam logic [7:0] AMP_BYTE_MAX = 8'hff;

  localparam logic [7:0] AMP_HI_RESET = 8'hff;
  localparam logic [7:0] AMP_FILL_RESET = 8'h00;
  localparam logic [AMP_MEM_BYTES-1:0][7:0] AMP_MEM_RESET =
    {{(AMP_MEM_BYTES - AMP_CHANNELS){AMP_FILL_RESET}}, {AMP_CHANNELS{AMP_HI_RESET}}};

  localparam int AMP_CLK_HZ = 25_000_000;
  localparam int AMP_ROLL_MS = 1000;
  localparam int AMP_ROLL_CYCLES = AMP_ROLL_MS * (AMP_CLK_HZ / 1000);
  localparam int AMP_ROLL_W = 25;

  typedef enum logic [1:0] {
    AMP_SEV_OFF = 2'h0,
    AMP_SEV_MINOR = 2'h1,
    AMP_SEV_MAJOR = 2'h2,
    AMP_SEV_CRIT = 2'h3
  } amp_sev_type;

  typedef enum logic [5:0] {
    AMP_ST_TITLE = 6'h01,
    AMP_ST_MENU = 6'h02,
    AMP_ST_SETSEL = 6'h04,
    AMP_ST_EDIT = 6'h08,
    AMP_ST_LIVE = 6'h10,
    AMP_ST_ALARMS = 6'h20
  } amp_menu_type;

  typedef struct packed {
    logic [AMP_ANALOG-1:0][7:0] value;
    logic pwr_good;
    logic pwr_fan;
  } amp_sense_type;

  typedef struct packed {
    logic up;
    logic down;
    logic confirm;
    logic menu_back_key;
    logic alarm_key;
    logic power_key;
  } amp_keys_type;

  typedef struct packed {
    logic minor;
    logic major;
    logic crit;
  } amp_relay_type;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] baud;
    logic modem_link;
  } amp_serial_type;

  typedef struct packed {
    amp_menu_type screen;
    logic [7:0] item;
    logic [7:0] value;
    logic [3:0] count;
  } amp_disp_type;

  typedef struct packed {
    amp_menu_type menu;
    logic [6:0] cursor;
    logic [1:0] main_sel;
    logic [7:0] shadow;
    logic [3:0] alarm_pos;
    logic [3:0] live_pos;
    logic [3:0] roll_pos;
    logic [AMP_ROLL_W-1:0] roll_cnt;
    logic silenced;
    logic power_on;
    logic [AMP_CHANNELS-1:0] active;
    logic [AMP_MEM_BYTES-1:0][7:0] mem;
    logic [7:0] rdata;
    amp_relay_type relay;
    logic buzzer;
    amp_serial_type serial;
    amp_disp_type disp;
  } amp_state_type;

endpackage

// ### design/amp_chan_cmp.sv
/*
  one sense channel: limit window or logic-level check, gated by severity.
  assumes limits and severity come from registered settings.
*/
`timescale 1ns/1ns
module amp_chan_cmp
  import amp_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] hi,
  input wire logic [W-1:0] lo,
  input wire logic logic_mode,
  input wire logic fail_level,
  input wire logic [1:0] sev,
  output logic fault
);

  logic raw;

  always_comb
  begin
    if (logic_mode)
      raw = (value[0] == fail_level);
    else
      raw = (value > hi) || (value < lo);
    fault = raw && (sev != AMP_SEV_OFF);
  end

endmodule

// ### design/amp_panel.sv
/*
  alarm evaluation, relays, buzzer, power key, display and keypad menu.
  assumes key inputs are one-cycle press pulses synchronous to clock and
  sensor values already converted to 8-bit codes.
*/
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
module amp_panel
  import amp_pkg::*;
#(
  parameter int ROLL_CYCLES = AMP_ROLL_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire amp_sense_type sense,
  input wire amp_keys_type keys,
  input wire logic main_supply_on,
  output amp_relay_type relay,
  output logic buzzer,
  output logic sys_power,
  output amp_serial_type serial,
  output amp_disp_type disp
);

  localparam logic [AMP_ROLL_W-1:0] ROLL_LAST = AMP_ROLL_W'(ROLL_CYCLES - 1);
  localparam logic [3:0] CHAN_LAST = 4'(AMP_CHANNELS - 1);
  localparam logic [3:0] ROLL_POS_LAST = 4'(AMP_ANALOG - 1);

  amp_state_type s;
  amp_state_type n;
  logic [AMP_CHANNELS-1:0] fault;
  logic [AMP_CHANNELS-1:0][7:0] chan_val;
  logic [7:0] cfg;

  assign cfg = s.mem[AMP_CFG_ADDR];

  // stored bytes saturate at the largest value that their field allows
  function automatic logic [7:0] field_max(input logic [6:0] a);
    if (a >= AMP_SEV_BASE && a <= AMP_SEV_LAST)
      return AMP_SEV_MAX;
    else if (a >= AMP_ID_BASE && a <= AMP_ID_LAST)
      return AMP_HEX_MAX;
    else if (a >= AMP_PHONE_BASE && a <= AMP_PHONE_LAST)
      return AMP_DEC_MAX;
    else
      return AMP_BYTE_MAX;
  endfunction

  function automatic logic [7:0] clip(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = field_max(a);
    if (d > m)
      return m;
    else
      return d;
  endfunction

  function automatic logic [3:0] nth_set(input logic [AMP_CHANNELS-1:0] v, input logic [3:0] k);
    logic [3:0] seen;
    logic [3:0] pick;
    seen = 4'h0;
    pick = 4'h0;
    for (int c = 0; c < AMP_CHANNELS; c++)
    begin
      if (v[c])
      begin
        if (seen == k)
          pick = 4'(c);
        seen = seen + 4'h1;
      end
    end
    return pick;
  endfunction

  for (genvar i = 0; i < AMP_CHANNELS; i++)
  begin : g_chan
    logic pol;
    if (i < AMP_ANALOG)
    begin : g_an
      assign chan_val[i] = sense.value[i];
      assign pol = 1'b0;
    end
    else if (i == AMP_ANALOG)
    begin : g_pg
      assign chan_val[i] = {7'h00, sense.pwr_good};
      assign pol = cfg[AMP_CFG_PG_POL];
    end
    else
    begin : g_pf
      assign chan_val[i] = {7'h00, sense.pwr_fan};
      assign pol = cfg[AMP_CFG_PF_POL];
    end
    amp_chan_cmp #(.W(8)) u_cmp (
      .value(chan_val[i]),
      .hi(s.mem[AMP_HI_BASE + i]),
      .lo(s.mem[AMP_LO_BASE + i]),
      .logic_mode(i >= AMP_ANALOG),
      .fail_level(pol),
      .sev(s.mem[AMP_SEV_BASE + i][1:0]),
      .fault(fault[i])
    );
  end

  always_comb
  begin
    logic [3:0] cnt;
    logic rmin;
    logic rmaj;
    logic rcrit;
    logic [7:0] top;
    logic last_digit;
    cnt = 4'h0;
    rmin = 1'b0;
    rmaj = 1'b0;
    rcrit = 1'b0;
    top = field_max(s.cursor);
    last_digit = 1'b0;
    n = s;
    n.rdata = 8'h00;
    n.active = fault;

    for (int c = 0; c < AMP_CHANNELS; c++)
    begin
      cnt = cnt + {3'h0, fault[c]};
      if (fault[c])
      begin
        case (amp_sev_type'(s.mem[AMP_SEV_BASE + c][1:0]))
          AMP_SEV_MINOR: rmin = 1'b1;
          AMP_SEV_MAJOR: rmaj = 1'b1;
          AMP_SEV_CRIT: rcrit = 1'b1;
          default: ;
        endcase
      end
    end
    n.relay.minor = rmin && cfg[AMP_CFG_MINOR];
    n.relay.major = rmaj && cfg[AMP_CFG_MAJOR];
    n.relay.crit = rcrit && cfg[AMP_CFG_CRIT];

    // a press that lands with the last fault clearing does not silence; silence clears
    if (keys.alarm_key && (fault != '0))
      n.silenced = 1'b1;
    else if (fault == '0)
      n.silenced = 1'b0;
    n.buzzer = (fault != '0) && cfg[AMP_CFG_BUZZ] && !n.silenced;

    if (!main_supply_on)
      n.power_on = 1'b0;
    else if (keys.power_key)
      n.power_on = !s.power_on;

    if (cfg[AMP_CFG_ROLL])
    begin
      if (s.roll_cnt == ROLL_LAST)
      begin
        n.roll_cnt = '0;
        n.roll_pos = (s.roll_pos == ROLL_POS_LAST) ? 4'h0 : s.roll_pos + 4'h1;
      end
      else
        n.roll_cnt = s.roll_cnt + AMP_ROLL_W'(1);
    end
    else
    begin
      n.roll_cnt = '0;
      n.roll_pos = 4'h0;
    end

    // host write lands first so a keypad commit in the same cycle wins
    if (wr && addr < 7'(AMP_MEM_BYTES))
      n.mem[addr] = clip(addr, wdata);

    case (s.menu)
      AMP_ST_TITLE:
      begin
        if (keys.confirm)
        begin
          n.menu = AMP_ST_MENU;
          n.main_sel = 2'h0;
        end
      end
      AMP_ST_MENU:
      begin
        if (keys.up)
          n.main_sel = (s.main_sel == 2'h0) ? 2'h2 : s.main_sel - 2'h1;
        else if (keys.down)
          n.main_sel = (s.main_sel == 2'h2) ? 2'h0 : s.main_sel + 2'h1;
        else if (keys.confirm)
        begin
          case (s.main_sel)
            2'h0: n.menu = AMP_ST_SETSEL;
            2'h1: n.menu = AMP_ST_LIVE;
            default: n.menu = AMP_ST_ALARMS;
          endcase
          n.cursor = 7'h00;
          n.live_pos = 4'h0;
          n.alarm_pos = 4'h0;
        end
        else if (keys.menu_back_key)
          n.menu = AMP_ST_TITLE;
      end
      AMP_ST_SETSEL:
      begin
        if (keys.up)
          n.cursor = (s.cursor == 7'h00) ? AMP_PHONE_LAST : s.cursor - 7'h01;
        else if (keys.down)
          n.cursor = (s.cursor == AMP_PHONE_LAST) ? 7'h00 : s.cursor + 7'h01;
        else if (keys.confirm)
        begin
          n.menu = AMP_ST_EDIT;
          n.shadow = s.mem[s.cursor];
        end
        else if (keys.menu_back_key)
          n.menu = AMP_ST_MENU;
      end
      AMP_ST_EDIT:
      begin
        last_digit = (s.cursor == AMP_ID_LAST) || (s.cursor == AMP_PHONE_LAST);
        if (keys.up)
          n.shadow = (s.shadow >= top) ? 8'h00 : s.shadow + 8'h01;
        else if (keys.down)
          n.shadow = (s.shadow == 8'h00) ? top : s.shadow - 8'h01;
        else if (keys.confirm)
        begin
          n.mem[s.cursor] = clip(s.cursor, s.shadow);
          if ((top == AMP_HEX_MAX || top == AMP_DEC_MAX) && !last_digit)
          begin
            n.cursor = s.cursor + 7'h01;
            n.shadow = s.mem[s.cursor + 7'h01];
          end
          else
            n.menu = AMP_ST_SETSEL;
        end
        else if (keys.menu_back_key)
          n.menu = AMP_ST_SETSEL;
      end
      AMP_ST_LIVE:
      begin
        if (keys.up)
          n.live_pos = (s.live_pos == 4'h0) ? CHAN_LAST : s.live_pos - 4'h1;
        else if (keys.down)
          n.live_pos = (s.live_pos == CHAN_LAST) ? 4'h0 : s.live_pos + 4'h1;
        else if (keys.menu_back_key)
          n.menu = AMP_ST_MENU;
      end
      AMP_ST_ALARMS:
      begin
        if (cnt == 4'h0 || s.alarm_pos >= cnt)
          n.alarm_pos = 4'h0;
        else if (keys.up)
          n.alarm_pos = (s.alarm_pos == 4'h0) ? cnt - 4'h1 : s.alarm_pos - 4'h1;
        else if (keys.down)
          n.alarm_pos = (s.alarm_pos == cnt - 4'h1) ? 4'h0 : s.alarm_pos + 4'h1;
        if (keys.menu_back_key)
          n.menu = AMP_ST_MENU;
      end
      default: n.menu = AMP_ST_TITLE;
    endcase

    n.serial.mode = s.mem[AMP_SER_ADDR][AMP_SER_MODE_LSB +: 2];
    n.serial.baud = s.mem[AMP_SER_ADDR][AMP_SER_BAUD_LSB +: 3];
    // dialling itself is the modem's job; only the link select is driven
    n.serial.modem_link = (n.serial.mode == AMP_DIALOUT_PORT_MODE);

    if (rd)
    begin
      if (addr < 7'(AMP_MEM_BYTES))
        n.rdata = s.mem[addr];
      else if (addr == AMP_STAT_LO_ADDR)
        n.rdata = s.active[7:0];
      else if (addr == AMP_STAT_HI_ADDR)
        n.rdata = {2'h0, s.active[13:8]};
      else if (addr == AMP_COUNT_ADDR)
        n.rdata = {4'h0, s.disp.count};
      else if (addr == AMP_POWER_ADDR)
        n.rdata = {7'h00, s.power_on};
    end

    n.disp.screen = n.menu;
    n.disp.count = cnt;
    n.disp.item = 8'h00;
    n.disp.value = 8'h00;
    case (n.menu)
      AMP_ST_TITLE:
      begin
        if (cfg[AMP_CFG_ROLL])
        begin
          n.disp.item = {4'h0, n.roll_pos};
          n.disp.value = chan_val[n.roll_pos];
        end
      end
      AMP_ST_MENU: n.disp.item = {6'h00, n.main_sel};
      AMP_ST_SETSEL:
      begin
        n.disp.item = {1'b0, n.cursor};
        n.disp.value = n.mem[n.cursor];
      end
      AMP_ST_EDIT:
      begin
        n.disp.item = {1'b0, n.cursor};
        n.disp.value = n.shadow;
      end
      AMP_ST_LIVE:
      begin
        n.disp.item = {4'h0, n.live_pos};
        n.disp.value = chan_val[n.live_pos];
      end
      AMP_ST_ALARMS:
      begin
        n.disp.item = {4'h0, nth_set(fault, n.alarm_pos)};
        n.disp.value = (cnt == 4'h0) ? 8'h00 : {4'h0, n.alarm_pos + 4'h1};
      end
      default: n.disp.item = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.menu <= AMP_ST_TITLE;
      s.mem <= AMP_MEM_RESET;
      s.disp.screen <= AMP_ST_TITLE;
    end
    else
      s <= n;
  end

  assign rdata = s.rdata;
  assign relay = s.relay;
  assign buzzer = s.buzzer;
  assign sys_power = s.power_on;
  assign serial = s.serial;
  assign disp = s.disp;

endmodule

// ### dv/amp_panel_assertions.sv
/*
  checker on the amp_panel ports: power key, buzzer silence, read data,
  serial mode and menu moves. assumes it is bound to every amp_panel.
*/
`timescale 1ns/1ns
module amp_panel_assertions
  import amp_pkg::*;
#(
  parameter int ROLL_CYCLES = 8
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire amp_sense_type sense,
  input wire amp_keys_type keys,
  input wire logic main_supply_on,
  input wire amp_relay_type relay,
  input wire logic buzzer,
  input wire logic sys_power,
  input wire amp_serial_type serial,
  input wire amp_disp_type disp
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_power_toggle: assert property (
    main_supply_on && keys.power_key |=> sys_power != $past(sys_power))
    else $error("power key did not toggle power");
  chk_power_hold: assert property (
    main_supply_on && !keys.power_key |=> $stable(sys_power))
    else $error("power changed without a key press");
  chk_power_off: assert property (
    !main_supply_on |=> !sys_power)
    else $error("power on while main supply off");
  chk_alarm_silence: assert property (
    keys.alarm_key && buzzer |=> !buzzer)
    else $error("alarm key did not silence buzzer");
  chk_rdata_idle: assert property (
    !rd |=> rdata == 8'h00)
    else $error("read data without a read");
  chk_serial_link: assert property (
    serial.modem_link == (serial.mode == AMP_DIALOUT_PORT_MODE))
    else $error("modem link flag disagrees with port mode");
  chk_screen_onehot: assert property (
    $onehot(disp.screen))
    else $error("screen code not one-hot");
  chk_title_confirm: assert property (
    disp.screen == AMP_ST_TITLE && keys.confirm && !keys.up && !keys.down
    |=> disp.screen == AMP_ST_MENU)
    else $error("confirm on title did not open menu");
  chk_back_key: assert property (
    disp.screen == AMP_ST_LIVE && keys.menu_back_key && !keys.up && !keys.down
    && !keys.confirm |=> disp.screen == AMP_ST_MENU)
    else $error("back key did not leave live view");
endmodule

bind amp_panel amp_panel_assertions #(.ROLL_CYCLES(ROLL_CYCLES)) u_chk (.clock, .rst, .addr,
  .wdata, .wr, .rd, .rdata, .sense, .keys, .main_supply_on, .relay, .buzzer, .sys_power,
  .serial, .disp);

// ### dv/amp_panel_model.sv
/*
  far-side model: sensor levels and debounced keypad press pulses.
  assumes the bench asks for one sensor change per request.
*/
`timescale 1ns/1ns
module amp_panel_model
  import amp_pkg::*;
(
  input wire logic clock,
  input wire logic load,
  input wire logic [3:0] sel,
  input wire logic [7:0] level,
  input wire amp_keys_type press,
  output amp_sense_type sense,
  output amp_keys_type keys
);
  initial
  begin
    sense = '0;
    sense.pwr_good = 1'b1;
    sense.pwr_fan = 1'b1;
    keys = '0;
  end

  // keys leave here as clean one-cycle pulses, as a debouncer would give
  always @(posedge clock)
  begin
    keys <= press;
    if (load)
    begin
      if (sel == 4'hc)
        sense.pwr_good <= level[0];
      else if (sel == 4'hd)
        sense.pwr_fan <= level[0];
      else
        sense.value[sel] <= level;
    end
  end
endmodule

// ### dv/amp_panel_tb.sv
/*
  self-checking bench for amp_panel: a table of channel faults, then
  register, buzzer, serial, power and keypad cases.
  assumes the far-side model and the bound checker.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module amp_panel_tb
  import amp_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic main_supply_on = 1'b1;
  logic load = 1'b0;
  logic [6:0] addr = '0;
  logic [7:0] wdata = '0;
  logic [7:0] level = '0;
  logic [3:0] sel = '0;
  amp_keys_type press = '0;
  logic [7:0] rdata;
  logic [7:0] v;
  logic buzzer;
  logic sys_power;
  amp_keys_type keys;
  amp_sense_type sense;
  amp_relay_type relay;
  amp_serial_type serial;
  amp_disp_type disp;
  int bad_count = 0;
  int samples_checked = 0;
  // ch, severity, value, config, relays {minor,major,crit}, buzzer, count
  typedef struct packed {
    logic [3:0] ch;
    logic [1:0] sev;
    logic [7:0] val;
    logic [7:0] cfg;
    logic [2:0] rel;
    logic buz;
    logic [3:0] cnt;
  } amp_row_type;
  amp_row_type rows [12] = '{
    {4'h0, 2'h3, 8'h81, 8'h1f, 3'h1, 1'b1, 4'h1}, {4'h0, 2'h3, 8'h80, 8'h1f, 3'h0, 1'b0, 4'h0},
    {4'h0, 2'h3, 8'h1f, 8'h1f, 3'h1, 1'b1, 4'h1}, {4'h0, 2'h3, 8'h20, 8'h1f, 3'h0, 1'b0, 4'h0},
    {4'h0, 2'h1, 8'hff, 8'h1f, 3'h4, 1'b1, 4'h1}, {4'h0, 2'h2, 8'h00, 8'h1f, 3'h2, 1'b1, 4'h1},
    {4'h0, 2'h0, 8'hff, 8'h1f, 3'h0, 1'b0, 4'h0}, {4'h0, 2'h3, 8'hff, 8'h0e, 3'h0, 1'b0, 4'h1},
    {4'h0, 2'h2, 8'hff, 8'h00, 3'h0, 1'b0, 4'h1}, {4'hc, 2'h3, 8'h01, 8'h3f, 3'h1, 1'b1, 4'h1},
    {4'hc, 2'h3, 8'h01, 8'h1f, 3'h0, 1'b0, 4'h0}, {4'hd, 2'h1, 8'h00, 8'h1f, 3'h4, 1'b1, 4'h1}};

  always #20 clock = ~clock;

  amp_panel #(.ROLL_CYCLES(8)) uut (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata, .sense,
    .keys, .main_supply_on, .relay, .buzzer, .sys_power, .serial, .disp);
  amp_panel_model far_end (.clock, .load, .sel, .level, .press, .sense, .keys);

  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [6:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    rreg(a, d);
    `CHK(d, e)
  endtask

  task automatic key(input amp_keys_type k);
    @(posedge clock);
    press <= k;
    @(posedge clock);
    press <= '0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic setv(input logic [3:0] c, input logic [7:0] d);
    @(posedge clock);
    load <= 1'b1;
    sel <= c;
    level <= d;
    @(posedge clock);
    load <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  initial
  begin
    repeat (5000) @(posedge clock);
    bad_count++;
    print_verdict();
  end

  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rchk(AMP_HI_BASE, AMP_HI_RESET);
    rchk(AMP_LO_BASE | 7'h0d, 8'h00);
    wreg(AMP_HI_BASE, 8'h80);
    wreg(AMP_LO_BASE, 8'h20);
    foreach (rows[i])
    begin
      setv(rows[i].ch, rows[i].val);
      wreg(AMP_SEV_BASE | {3'h0, rows[i].ch}, {6'h00, rows[i].sev});
      wreg(AMP_CFG_ADDR, rows[i].cfg);
      settle();
      `CHK(relay, rows[i].rel)
      `CHK(buzzer, rows[i].buz)
      rchk(AMP_COUNT_ADDR, {4'h0, rows[i].cnt});
      wreg(AMP_SEV_BASE | {3'h0, rows[i].ch}, 8'h00);
    end
    // status is read-only, and an unmapped address out of range reads zero
    wreg(AMP_STAT_LO_ADDR, 8'hff);
    rchk(AMP_STAT_LO_ADDR, 8'h00);
    rchk(7'h60, 8'h00);
    wreg(AMP_ID_BASE, 8'hff);
    rchk(AMP_ID_BASE, AMP_HEX_MAX);
    wreg(AMP_PHONE_LAST, 8'h0c);
    rchk(AMP_PHONE_LAST, AMP_DEC_MAX);
    wreg(AMP_SEV_LAST, 8'h07);
    rchk(AMP_SEV_LAST, 8'h03);
    rchk(AMP_STAT_HI_ADDR, 8'h20);
    `CHK(buzzer, 1'b1)
    key(6'h02);
    `CHK(buzzer, 1'b0)
    setv(4'hd, 8'h01);
    settle();
    setv(4'hd, 8'h00);
    settle();
    `CHK(buzzer, 1'b1)
    `CHK(relay, 3'h1)
    wreg(AMP_SEV_LAST, 8'h00);
    for (int m = 0; m < 3; m++)
    begin
      wreg(AMP_SER_ADDR, {3'h0, 3'h5, m[1:0]});
      settle();
      `CHK(serial.mode, m[1:0])
      `CHK(serial.baud, 3'h5)
      `CHK(serial.modem_link, m == 2)
    end
    key(6'h01);
    `CHK(sys_power, 1'b1)
    // supply loss must force power off even with power on
    @(posedge clock);
    main_supply_on <= 1'b0;
    key(6'h01);
    `CHK(sys_power, 1'b0)
    @(posedge clock);
    main_supply_on <= 1'b1;
    key(6'h01);
    rchk(AMP_POWER_ADDR, 8'h01);
    key(6'h01);
    `CHK(sys_power, 1'b0)
    // rolling steps one channel every ROLL_CYCLES edges
    v = disp.item;
    repeat (8) @(posedge clock);
    #1;
    `CHK(disp.item, (v == 8'h0b) ? 8'h00 : v + 8'h01)
    wreg(AMP_CFG_ADDR, 8'h1d);
    settle();
    `CHK(disp.item, 8'h00)
    // down steps settings, live, alarms
    key(6'h08);
    `CHK(disp.screen, AMP_ST_MENU)
    key(6'h10);
    key(6'h08);
    `CHK(disp.screen, AMP_ST_LIVE)
    `CHK(disp.value, 8'hff)
    key(6'h10);
    `CHK(disp.item, 8'h01)
    key(6'h04);
    `CHK(disp.screen, AMP_ST_MENU)
    key(6'h10);
    key(6'h08);
    `CHK(disp.screen, AMP_ST_ALARMS)
    `CHK(disp.count, 4'h0)
    wreg(AMP_SEV_LAST, 8'h01);
    settle();
    `CHK(disp.count, 4'h1)
    `CHK(disp.item, 8'h0d)
    `CHK(disp.value, 8'h01)
    wreg(AMP_SEV_LAST, 8'h00);
    key(6'h04);
    key(6'h10);
    key(6'h08);
    `CHK(disp.screen, AMP_ST_SETSEL)
    key(6'h08);
    key(6'h20);
    key(6'h08);
    rreg(AMP_HI_BASE, v);
    `CHK(v, 8'h81)
    key(6'h08);
    key(6'h20);
    key(6'h04);
    rchk(AMP_HI_BASE, v);
    key(6'h20);
    `CHK(disp.item, 8'h4f)
    key(6'h08);
    key(6'h20);
    `CHK(disp.value, 8'h00)
    key(6'h08);
    rchk(AMP_PHONE_LAST, 8'h00);
    // reset in mid-run must drop power and restore limits
    key(6'h01);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    `CHK(sys_power, 1'b0)
    `CHK(disp.screen, AMP_ST_TITLE)
    rchk(AMP_HI_BASE, AMP_HI_RESET);
    print_verdict();
  end
endmodule
